/* shared/cij_pkg.sv */
// Package with constants and carrier types for the compare-jump executor
package cij_pkg;
    // Opcode of the compare-increment-jump-on-equal instruction
    localparam logic [7:0] CIJ_OPC_CIJE = 8'hC2;
    // Instruction length in bytes
    localparam logic [15:0] CIJ_INSTR_LEN = 16'h0003;
    // Cycle counts, taken and not taken
    localparam int CIJ_CYC_TAKEN = 18;
    localparam int CIJ_CYC_NOT_TAKEN = 16;
    // Counter width for the cycle count
    localparam int CIJ_CNT_W = 5;
    // Flag bit positions inside the flag byte
    localparam int CIJ_FLAG_C = 7;
    localparam int CIJ_FLAG_Z = 6;
    localparam int CIJ_FLAG_S = 5;
    localparam int CIJ_FLAG_V = 4;
    // Field positions of the register byte
    localparam int CIJ_DST_HI = 7;
    localparam int CIJ_DST_LO = 4;
    localparam int CIJ_SRC_HI = 3;
    localparam int CIJ_SRC_LO = 0;
    // Pointer increment step
    localparam logic [7:0] CIJ_PTR_STEP = 8'h01;
    // Sign bit of a byte
    localparam int CIJ_MSB = 7;

    // Request presented by the fetch stage
    typedef struct packed {
        logic is_compare;     // Plain compare, not the jump form
        logic [7:0] opcode;   // First byte
        logic [7:0] regs;     // Dst and src register nibbles
        logic [7:0] offset;   // Relative offset byte
        logic [15:0] pc;      // Address of first instruction byte
        logic [7:0] dst_val;  // Destination register value
        logic [7:0] src_val;  // Operand read through the pointer
        logic [7:0] ptr_val;  // Current pointer register value
        logic [7:0] flags;    // Current flag byte
    } cij_req_t;

    // Result handed back to the core
    typedef struct packed {
        logic [15:0] next_pc;  // Address of next instruction
        logic [3:0] ptr_idx;   // Which working reg gets the pointer
        logic [7:0] ptr_val;   // Updated pointer value
        logic ptr_we;          // Write pointer back
        logic [7:0] flags;     // Flag byte after execution
        logic taken;           // Branch taken
    } cij_rsp_t;

    // Executor states, Gray-coded along the jump-form path; compare goes IDLE to DONE in two bits
    typedef enum logic [1:0] {
        CIJ_IDLE = 2'b00,
        CIJ_BUSY = 2'b01,
        CIJ_DONE = 2'b11
    } cij_state_t;
endpackage

/* verilog/cij_exec.sv */
// Executor for compare-increment-jump-on-equal and plain compare flags
`timescale 1ns/1ps
module cij_exec
    import cij_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire cij_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output cij_rsp_t rsp,
    output logic illegal
);

    //--------------------------------------------------------------
    // Combinational evaluation
    //--------------------------------------------------------------

    // Difference with borrow out
    logic [8:0] diff;
    // Signed offset widened to the program counter
    logic [15:0] offset_ext;
    // Request is the jump form
    logic is_cije;
    // Flags computed for a plain compare
    logic [7:0] cmp_flags;
    // Evaluated response
    cij_rsp_t eval;

    always_comb
    begin
        diff = {1'b0, req.dst_val} - {1'b0, req.src_val};
        offset_ext = {{8{req.offset[CIJ_MSB]}}, req.offset};
        is_cije = (req.opcode == CIJ_OPC_CIJE) && !req.is_compare;
        // Plain compare flags; D and H bits pass through
        cmp_flags = req.flags;
        cmp_flags[CIJ_FLAG_C] = diff[8];
        cmp_flags[CIJ_FLAG_Z] = (diff[7:0] == 8'h00);
        cmp_flags[CIJ_FLAG_S] = diff[CIJ_MSB];
        cmp_flags[CIJ_FLAG_V] = (req.dst_val[CIJ_MSB] != req.src_val[CIJ_MSB])
            && (diff[CIJ_MSB] != req.dst_val[CIJ_MSB]);
        eval = '0;
        if (req.is_compare)
        begin
            // Plain compare: flags only, pc untouched
            eval.next_pc = req.pc;
            eval.flags = cmp_flags;
        end
        else
        begin
            // Jump form: pc past the three bytes, then maybe relative
            eval.taken = (diff[7:0] == 8'h00);
            eval.next_pc = req.pc + CIJ_INSTR_LEN;
            if (eval.taken)
            begin
                eval.next_pc = req.pc + CIJ_INSTR_LEN
                    + offset_ext;
            end
            eval.ptr_idx = req.regs[CIJ_SRC_HI:CIJ_SRC_LO];
            eval.ptr_val = req.ptr_val + CIJ_PTR_STEP;
            eval.ptr_we = 1'b1;
            eval.flags = req.flags;
        end
    end

    //--------------------------------------------------------------
    // Sequencing
    //--------------------------------------------------------------

    // Present state
    cij_state_t state;
    cij_state_t next_state;
    // Remaining wait cycles
    logic [CIJ_CNT_W-1:0] cnt;
    logic [CIJ_CNT_W-1:0] next_cnt;
    // Held result
    cij_rsp_t held;
    cij_rsp_t next_held;
    // Illegal-opcode pulse
    logic next_illegal;

    // Next-state logic
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_held = held;
        next_illegal = 1'b0;
        unique case (state)
            CIJ_IDLE:
            begin
                if (req_valid && (is_cije || req.is_compare))
                begin
                    next_held = eval;
                    if (req.is_compare)
                    begin
                        // Compare answers next cycle
                        next_state = CIJ_DONE;
                    end
                    else
                    begin
                        // Done in cycle N counting take as cycle 1
                        next_state = CIJ_BUSY;
                        // Take, count down to zero, then the DONE cycle
                        next_cnt = eval.taken
                            ? CIJ_CNT_W'(CIJ_CYC_TAKEN - 3)
                            : CIJ_CNT_W'(CIJ_CYC_NOT_TAKEN - 3);
                    end
                end
                else if (req_valid)
                begin
                    // Unknown opcode is dropped and flagged
                    next_illegal = 1'b1;
                end
            end
            CIJ_BUSY:
            begin
                if (cnt == '0)
                begin
                    next_state = CIJ_DONE;
                end
                else
                begin
                    next_cnt = cnt - 1'b1;
                end
            end
            CIJ_DONE:
            begin
                next_state = CIJ_IDLE;
            end
            default:
            begin
                next_state = CIJ_IDLE;
            end
        endcase
    end

    // Register stage
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            state <= CIJ_IDLE;
            cnt <= '0;
            held <= '0;
            illegal <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            held <= next_held;
            illegal <= next_illegal;
        end
    end

    // Handshake and data outputs
    assign req_ready = (state == CIJ_IDLE);
    assign rsp_valid = (state == CIJ_DONE);
    assign rsp = held;

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------

    a_taken_cycles: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (state == CIJ_IDLE && req_valid && is_cije && eval.taken)
        |-> ##17 rsp_valid)
        else $error("taken jump not answered in 18 cycles");
    a_nt_cycles: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (state == CIJ_IDLE && req_valid && is_cije && !eval.taken)
        |-> !rsp_valid [*8] ##7 !rsp_valid ##1 rsp_valid)
        else $error("untaken jump not answered in 16 cycles");
    a_ptr_incr: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (state == CIJ_IDLE && req_valid && is_cije)
        |=> held.ptr_we && held.ptr_val == $past(req.ptr_val) + 8'h01)
        else $error("pointer not incremented");
    a_flags_kept: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (state == CIJ_IDLE && req_valid && is_cije)
        |=> held.flags == $past(req.flags))
        else $error("jump form changed flags");
    a_fall_thru: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (state == CIJ_IDLE && req_valid && is_cije
            && req.dst_val != req.src_val)
        |=> !held.taken && held.next_pc == $past(req.pc) + 16'h0003)
        else $error("unequal did not fall through");
    a_branch_eq: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (state == CIJ_IDLE && req_valid && is_cije
            && req.dst_val == req.src_val)
        |=> held.taken && held.next_pc == $past(req.pc) + 16'h0003
            + {{8{$past(req.offset[7])}}, $past(req.offset)})
        else $error("equal did not branch");
    a_cmp_carry: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (state == CIJ_IDLE && req_valid && req.is_compare)
        |=> held.flags[CIJ_FLAG_C]
            == ($past(req.dst_val) < $past(req.src_val)))
        else $error("compare carry wrong");
    a_cmp_zero: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (state == CIJ_IDLE && req_valid && req.is_compare)
        |=> held.flags[CIJ_FLAG_Z]
            == ($past(req.dst_val) == $past(req.src_val))
            && held.flags[3:0] == $past(req.flags[3:0]))
        else $error("compare zero or kept bits wrong");
    a_ptr_wrap: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (state == CIJ_IDLE && req_valid && is_cije && req.ptr_val == 8'hFF)
        |=> held.ptr_val == 8'h00)
        else $error("pointer did not wrap");

    c_taken: cover property (@(posedge ref_clk) disable iff (!nrst)
        state == CIJ_IDLE && req_valid && is_cije && eval.taken);
    c_not_taken: cover property (@(posedge ref_clk) disable iff (!nrst)
        state == CIJ_IDLE && req_valid && is_cije && !eval.taken);
    c_compare: cover property (@(posedge ref_clk) disable iff (!nrst)
        state == CIJ_IDLE && req_valid && req.is_compare && diff[8]);
    c_illegal: cover property (@(posedge ref_clk) disable iff (!nrst)
        illegal);

endmodule

/* verification/compare_increment_jump_equal_tb.sv */
// Self-checking testbench for the compare-jump executor
`timescale 1ns/1ps
module compare_increment_jump_equal_tb
    import cij_pkg::*;
;
    // ------------------------------------------------------------
    // Clock, reset and design hookup
    // ------------------------------------------------------------
    logic ref_clk = 1'b0; // Core clock, 4 ns period
    logic nrst = 1'b0; // Sync reset, active low
    logic req_valid = 1'b0; // Request strobe
    cij_req_t req = '0; // Request carrier
    logic req_ready; // Executor idle
    logic rsp_valid; // Result pulse
    cij_rsp_t rsp; // Result carrier
    logic illegal; // Unknown opcode pulse
    int err_total = 0; // Mismatch count
    int tests_run = 0; // Comparison count
    int cyc = 0; // Cycles since time zero

    // Half-period toggle
    always #2 ref_clk = ~ref_clk;

    cij_exec u_dut (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .req_valid(req_valid),
        .req(req),
        .req_ready(req_ready),
        .rsp_valid(rsp_valid),
        .rsp(rsp),
        .illegal(illegal)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    // Verdict and end of run
    task automatic stop_test();
        if (err_total == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Compare one value, report on mismatch
    task automatic chk(input string name, input logic [31:0] got,
                       input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask

    // Offer one request, wait for the answer, check its timing
    task automatic run_op(input cij_req_t r, input int edges);
        int n;
        @(negedge ref_clk);
        req_valid = 1'b1;
        req = r;
        @(negedge ref_clk);
        req_valid = 1'b0;
        chk("ready_busy", req_ready, 32'h0);
        n = 0;
        // Bounded wait for the result pulse
        while (rsp_valid !== 1'b1 && n < 40)
        begin
            @(negedge ref_clk);
            n++;
        end
        // Pulse seen n falling edges after the first; take edge adds one
        chk("answer_edges", n + 1, edges);
        @(negedge ref_clk);
        chk("pulse_width", rsp_valid, 32'h0);
        chk("ready_back", req_ready, 32'h1);
    endtask

    // One jump-form case and its result fields
    task automatic jump_case(input cij_req_t r, input logic tk,
                             input logic [15:0] pc, input logic [7:0] ptr);
        run_op(r, tk ? CIJ_CYC_TAKEN - 1 : CIJ_CYC_NOT_TAKEN - 1);
        chk("taken", rsp.taken, tk);
        chk("next_pc", rsp.next_pc, pc);
        chk("ptr_val", rsp.ptr_val, ptr);
        chk("ptr_we", rsp.ptr_we, 32'h1);
        chk("ptr_idx", rsp.ptr_idx, r.regs[3:0]);
        chk("jump_flags", rsp.flags, r.flags);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Equal operands, offsets at both ends of the signed range
    task automatic t_jump_taken();
        jump_case('{1'b0, 8'hC2, 8'h3B, 8'h80, 16'h0010, 8'h5A, 8'h5A,
                    8'hFF, 8'hF5}, 1'b1, 16'hFF93, 8'h00);
        jump_case('{1'b0, 8'hC2, 8'h12, 8'h7F, 16'h1234, 8'h02, 8'h02,
                    8'h03, 8'h0A}, 1'b1, 16'h12B6, 8'h04);
    endtask

    // Unequal operands fall through past three bytes
    task automatic t_jump_fall();
        jump_case('{1'b0, 8'hC2, 8'h4E, 8'h7F, 16'h2000, 8'h04, 8'h02,
                    8'h7F, 8'hA3}, 1'b0, 16'h2003, 8'h80);
    endtask

    // Plain compare flag table: borrow, equal, overflow both ways
    task automatic t_compare();
        cij_req_t r;
        logic [7:0] dv[4] = '{8'h05, 8'h3C, 8'h80, 8'h7F};
        logic [7:0] sv[4] = '{8'h0A, 8'h3C, 8'h01, 8'hFF};
        logic [7:0] fi[4] = '{8'h0A, 8'hF5, 8'h03, 8'h00};
        logic [7:0] fo[4] = '{8'hAA, 8'h45, 8'h13, 8'hB0};
        for (int i = 0; i < 4; i++)
        begin
            r = '{1'b1, 8'hA2, 8'h12, 8'h00, 16'h0300, dv[i], sv[i],
                  8'h20, fi[i]};
            run_op(r, 1);
            chk("cmp_flags", rsp.flags, fo[i]);
            chk("cmp_ptr_we", rsp.ptr_we, 32'h0);
            chk("cmp_pc", rsp.next_pc, 16'h0300);
        end
    endtask

    // Unknown opcode is dropped with a one-cycle flag
    task automatic t_illegal();
        @(negedge ref_clk);
        req_valid = 1'b1;
        req = '{1'b0, 8'hC3, 8'h12, 8'h05, 16'h0400, 8'h01, 8'h01,
                8'h10, 8'h00};
        @(negedge ref_clk);
        req_valid = 1'b0;
        chk("illegal_hi", illegal, 32'h1);
        chk("no_answer", rsp_valid, 32'h0);
        @(negedge ref_clk);
        chk("illegal_lo", illegal, 32'h0);
        chk("still_idle", req_ready, 32'h1);
    endtask

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_total++;
            stop_test();
        end
    end

    initial
    begin
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        nrst = 1'b1;
        t_jump_taken();
        t_jump_fall();
        t_compare();
        t_illegal();
        t_jump_taken();
        stop_test();
    end
endmodule
